// file: cgsr_clock_gen.sv
// Clock select, post divider and reset/status flags with APB register access
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "cgsr_regs.svh"

module cgsr_clock_gen #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk, // Bus clock, 250 MHz
   input wire logic presetn, // System reset, async, active low
   input wire logic poweron_rst_n, // Power-on reset, async, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [ADDR_W-1:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB byte strobes
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   input wire logic vco_tick, // One pulse per VCO clock period
   input wire logic osc_tick, // One pulse per oscillator clock period
   input wire logic periodic_tick_event, // Tick timer period end
   input wire logic undervoltage_reset_event, // Undervoltage reset seen
   input wire logic bad_address_reset_event, // Bad-address reset seen
   input wire logic pll_tolerance_status, // Raw PLL in-tolerance level
   input wire logic fallback_clock_active, // Raw fallback clock mode level
   input wire logic oscillator_config_status, // Oscillator configuration strap
   input wire logic wait_mode, // Part in wait mode
   input wire logic stop_mode, // Part in stop mode
   input wire logic special_mode, // Special operating mode
   output logic pll_output_tick, // Post-divided VCO pulse
   output logic system_bus_tick, // Bus rate pulse
   output logic pll_clock_select, // PLL drives system clock
   output logic pll_power_down, // PLL held down in wait
   output logic oscillator_enable, // Oscillator running
   output logic tick_timer_hold, // Tick timer stopped
   output logic tick_timer_reinit, // Tick dividers reinitialise
   output logic watchdog_hold, // Watchdog stopped
   output logic watchdog_reinit, // Watchdog counter reinitialise
   output logic irq_request // Interrupt request
);

   cgsr_pkg::cgsr_state_type state_reg;
   cgsr_pkg::cgsr_state_type state_next;
   cgsr_pkg::cgsr_flags_type flags_reg;
   cgsr_pkg::cgsr_flags_type flags_next;

   logic setup;
   logic access;
   logic wr_pll_post_divider;
   logic wr_flags;
   logic wr_irqen;
   logic wr_clock_source_select;
   logic [7:0] wbyte;
   logic [7:0] clr;
   logic lock_now;
   logic wait_entry;
   logic stop_entry;
   logic fb_entry;
   logic pll_pulse;
   logic src_pulse;

   // Register hit for one index; decode used for read and write
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
      reg_hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
   endfunction : reg_hit

   // Read value of the flag register
   function automatic logic [7:0] flags_view(input cgsr_pkg::cgsr_flags_type f,
                                             input logic lk, input logic fb);
      logic [7:0] v;
      v = `CGSR_BYTE_ZERO;
      v[`CGSR_FLG_TICK] = f.tick;
      v[`CGSR_FLG_POR] = f.por;
      v[`CGSR_FLG_UV] = f.uv;
      v[`CGSR_FLG_LCHG] = f.lchg;
      v[`CGSR_FLG_LOCK] = lk;
      v[`CGSR_FLG_BADA] = f.bada;
      v[`CGSR_FLG_FCHG] = f.fchg;
      v[`CGSR_FLG_FB] = fb;
      flags_view = v;
   endfunction : flags_view

   // Bus phase decode; writes land only in the access phase
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wbyte = pstrb[0] ? pwdata[7:0] : `CGSR_BYTE_ZERO;
   assign wr_pll_post_divider = access & pwrite & reg_hit(paddr, `CGSR_IDX_PLL_POST_DIVIDER);
   assign wr_flags = access & pwrite & reg_hit(paddr, `CGSR_IDX_FLAGS);
   assign wr_irqen = access & pwrite & pstrb[0] & reg_hit(paddr, `CGSR_IDX_IRQEN);
   assign wr_clock_source_select = access & pwrite & pstrb[0] & reg_hit(paddr, `CGSR_IDX_CLOCK_SOURCE_SELECT);
   assign clr = wr_flags ? wbyte : `CGSR_BYTE_ZERO;

   // Lock reads zero in fallback mode, so a fallback entry while locked also counts as a lock change
   assign lock_now = state_reg.lock_s2 & ~state_reg.fb_s2;
   assign wait_entry = wait_mode & ~state_reg.wait_d;
   assign stop_entry = stop_mode & ~state_reg.stop_d;
   assign fb_entry = state_reg.fb_s2 & ~state_reg.fb_d;

   // Post divider: bypass at zero, else one pulse per 2*value VCO pulses
   always_comb begin
      pll_pulse = 1'b0;
      if (vco_tick) begin
         if (state_reg.pll_post_divider == `CGSR_PLL_POST_DIVIDER_RST) begin
            pll_pulse = 1'b1;
         end else if (state_reg.div_cnt >= ({state_reg.pll_post_divider, 1'b0} - `CGSR_CNT_ONE)) begin
            pll_pulse = 1'b1;
         end
      end
   end

   // Bus rate source follows the PLL select bit
   assign src_pulse = state_reg.sel_pll ? pll_pulse : osc_tick;

   // Sticky flags; a set in the same cycle as its clear wins
   always_comb begin
      flags_next = flags_reg;
      flags_next.tick = (flags_reg.tick & ~clr[`CGSR_FLG_TICK]) | periodic_tick_event;
      flags_next.por = flags_reg.por & ~clr[`CGSR_FLG_POR];
      flags_next.uv = (flags_reg.uv & ~clr[`CGSR_FLG_UV]) | undervoltage_reset_event;
      flags_next.lchg = (flags_reg.lchg & ~clr[`CGSR_FLG_LCHG])
                        | (lock_now != state_reg.lock_d);
      flags_next.fchg = (flags_reg.fchg & ~clr[`CGSR_FLG_FCHG])
                        | (state_reg.fb_s2 != state_reg.fb_d);
      // Undervoltage reset clears it unless a new bad-address reset comes with it
      if (bad_address_reset_event) begin
         flags_next.bada = 1'b1;
      end else if (undervoltage_reset_event) begin
         flags_next.bada = 1'b0;
      end else begin
         flags_next.bada = flags_reg.bada & ~clr[`CGSR_FLG_BADA];
      end
   end

   // Everything on the system reset
   always_comb begin
      state_next = state_reg;
      // Two-stage synchronisers for the analog status levels and the strap
      state_next.lock_s1 = pll_tolerance_status;
      state_next.lock_s2 = state_reg.lock_s1;
      state_next.lock_d = lock_now;
      state_next.fb_s1 = fallback_clock_active;
      state_next.fb_s2 = state_reg.fb_s1;
      state_next.fb_d = state_reg.fb_s2;
      state_next.osc_s1 = oscillator_config_status;
      state_next.osc_s2 = state_reg.osc_s1;
      state_next.wait_d = wait_mode;
      state_next.stop_d = stop_mode;

      // Post divider value frozen while the PLL clocks the system
      if (wr_pll_post_divider && pstrb[0] && !state_reg.sel_pll) begin
         state_next.pll_post_divider = wbyte[`CGSR_PLL_POST_DIVIDER_W-1:0];
      end

      if (wr_irqen) begin
         state_next.tick_en = wbyte[`CGSR_FLG_TICK];
         state_next.lchg_en = wbyte[`CGSR_FLG_LCHG];
         state_next.fchg_en = wbyte[`CGSR_FLG_FCHG];
      end

      if (wr_clock_source_select) begin
         // A set is refused while the PLL is out of tolerance
         if (!wbyte[`CGSR_SEL_PLL]) begin
            state_next.sel_pll = 1'b0;
         end else if (lock_now) begin
            state_next.sel_pll = 1'b1;
         end
         state_next.keep = wbyte[`CGSR_SEL_KEEP];
         state_next.pll_halt_in_wait = wbyte[`CGSR_SEL_PLL_HALT_IN_WAIT];
         state_next.tickwai = wbyte[`CGSR_SEL_TICKWAI];
         // Watchdog halt bit locks after the first write outside special modes
         if (special_mode || !state_reg.wd_written) begin
            state_next.wdwai = wbyte[`CGSR_SEL_WDWAI];
         end
         if (!special_mode) begin
            state_next.wd_written = 1'b1;
         end
      end

      // Fallback and stop entries, and wait entry with pll_halt_in_wait set, drop the PLL select and win over a write in the same cycle
      if (fb_entry || stop_entry || (wait_entry && state_reg.pll_halt_in_wait)) begin
         state_next.sel_pll = 1'b0;
      end

      // Post divider counter
      if (vco_tick) begin
         if (pll_pulse) begin
            state_next.div_cnt = `CGSR_CNT_ZERO;
         end else begin
            state_next.div_cnt = state_reg.div_cnt + `CGSR_CNT_ONE;
         end
      end
      state_next.pll_tick = pll_pulse;

      // Divide the selected source by two
      if (src_pulse) begin
         state_next.half = ~state_reg.half;
      end
      state_next.bus_tick = src_pulse & state_reg.half;

      // Power and timer controls in the low-power modes
      state_next.osc_en = ~(stop_mode & ~state_reg.keep);
      state_next.pll_pd = wait_mode & state_reg.pll_halt_in_wait;
      state_next.tick_hold = wait_mode & state_reg.tickwai;
      state_next.tick_reinit = wait_entry & state_reg.tickwai;
      state_next.wd_hold = wait_mode & state_reg.wdwai;
      state_next.wd_reinit = wait_entry & state_reg.wdwai;

      // Request follows the updated flags and enables, so it never lags the flag view
      state_next.irq = (flags_next.tick & state_next.tick_en)
                       | (flags_next.lchg & state_next.lchg_en)
                       | (flags_next.fchg & state_next.fchg_en);

      // Read data captured in the setup phase, so the access phase answers at once
      if (setup) begin
         state_next.pslverr = 1'b0;
         state_next.prdata = 32'h0000_0000;
         if (reg_hit(paddr, `CGSR_IDX_PLL_POST_DIVIDER)) begin
            state_next.prdata[`CGSR_PLL_POST_DIVIDER_W-1:0] = state_reg.pll_post_divider;
         end else if (reg_hit(paddr, `CGSR_IDX_FLAGS)) begin
            state_next.prdata[7:0] = flags_view(flags_reg, lock_now, state_reg.fb_s2);
         end else if (reg_hit(paddr, `CGSR_IDX_IRQEN)) begin
            state_next.prdata[`CGSR_FLG_TICK] = state_reg.tick_en;
            state_next.prdata[`CGSR_FLG_LCHG] = state_reg.lchg_en;
            state_next.prdata[`CGSR_FLG_FCHG] = state_reg.fchg_en;
         end else if (reg_hit(paddr, `CGSR_IDX_CLOCK_SOURCE_SELECT)) begin
            state_next.prdata[`CGSR_SEL_PLL] = state_reg.sel_pll;
            state_next.prdata[`CGSR_SEL_KEEP] = state_reg.keep;
            state_next.prdata[`CGSR_SEL_OSCCFG] = state_reg.osc_s2;
            state_next.prdata[`CGSR_SEL_PLL_HALT_IN_WAIT] = state_reg.pll_halt_in_wait;
            state_next.prdata[`CGSR_SEL_TICKWAI] = state_reg.tickwai;
            state_next.prdata[`CGSR_SEL_WDWAI] = state_reg.wdwai;
         end else begin
            state_next.pslverr = 1'b1;
         end
      end
   end

   // Flags are reset only on power-on, not on the system reset; power-on itself is recorded at reset
   always_ff @(posedge pclk or negedge poweron_rst_n) begin
      if (!poweron_rst_n) begin
         flags_reg <= '{tick: 1'b0, por: 1'b1, uv: 1'b0, lchg: 1'b0,
                        bada: 1'b0, fchg: 1'b0};
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Control state on the system reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
         state_reg.pll_post_divider <= `CGSR_PLL_POST_DIVIDER_RST;
         state_reg.osc_en <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flip-flops, except pslverr gated with the access phase and pready tied high
   assign prdata = state_reg.prdata;
   assign pslverr = state_reg.pslverr & access;
   assign pready = 1'b1;
   assign pll_output_tick = state_reg.pll_tick;
   assign system_bus_tick = state_reg.bus_tick;
   assign pll_clock_select = state_reg.sel_pll;
   assign pll_power_down = state_reg.pll_pd;
   assign oscillator_enable = state_reg.osc_en;
   assign tick_timer_hold = state_reg.tick_hold;
   assign tick_timer_reinit = state_reg.tick_reinit;
   assign watchdog_hold = state_reg.wd_hold;
   assign watchdog_reinit = state_reg.wd_reinit;
   assign irq_request = state_reg.irq;

   // Checks on the design's own behaviour
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !poweron_rst_n);

   sequence s_sel_write_one;
      wr_clock_source_select && wbyte[`CGSR_SEL_PLL];
   endsequence

   a_pll_post_divider_frozen: assert property (
      (wr_pll_post_divider && state_reg.sel_pll) |=> $stable(state_reg.pll_post_divider))
      else $error("post divider changed while PLL selected");

   a_divider_bypass: assert property (
      (vco_tick && state_reg.pll_post_divider == `CGSR_PLL_POST_DIVIDER_RST) |=> pll_output_tick)
      else $error("zero post divider did not pass VCO pulse");

   a_select_needs_lock: assert property (
      (s_sel_write_one ##0 (!lock_now && !state_reg.sel_pll)) |=> !pll_clock_select)
      else $error("PLL selected while out of tolerance");

   a_select_stop_clear: assert property (
      stop_entry |=> !pll_clock_select)
      else $error("PLL select kept on stop entry");

   // Flag stands after the event and only drops one edge after a clear
   sequence s_tick_kept;
      flags_reg.tick ##1 (flags_reg.tick || $past(clr[`CGSR_FLG_TICK]));
   endsequence

   a_tick_flag_sticky: assert property (
      periodic_tick_event |=> s_tick_kept)
      else $error("tick flag lost without a clear");

   a_bada_cleared_uv: assert property (
      (undervoltage_reset_event && !bad_address_reset_event) |=> !flags_reg.bada)
      else $error("bad-address flag kept after undervoltage reset");

   a_lock_change_flag: assert property (
      (lock_now != $past(lock_now)) |=> flags_reg.lchg)
      else $error("tolerance change not flagged");

   a_lock_zero_fallback: assert property (
      (setup && reg_hit(paddr, `CGSR_IDX_FLAGS) && state_reg.fb_s2)
      |=> !prdata[`CGSR_FLG_LOCK])
      else $error("lock shown in fallback mode");

   a_irq_gate: assert property (
      (flags_reg.tick && state_reg.tick_en) |-> irq_request)
      else $error("enabled tick flag without interrupt");

   a_wd_write_once: assert property (
      (wr_clock_source_select && state_reg.wd_written && !special_mode) |=> $stable(state_reg.wdwai))
      else $error("watchdog halt bit rewritten in normal mode");

   a_osc_stop: assert property (
      (stop_mode && !state_reg.keep) |=> !oscillator_enable)
      else $error("oscillator left on in stop");

   a_fchg_flag_set: assert property (
      (state_reg.fb_s2 != state_reg.fb_d) |=> flags_reg.fchg)
      else $error("fallback change not flagged");

   a_uv_flag_set: assert property (
      undervoltage_reset_event |=> flags_reg.uv)
      else $error("undervoltage flag not set");

   a_wait_select_clear: assert property (
      (wait_entry && state_reg.pll_halt_in_wait) |=> (!pll_clock_select && pll_power_down))
      else $error("PLL still selected or powered in wait");

   a_wait_reinit: assert property (
      (wait_entry && state_reg.tickwai) |=> (tick_timer_reinit && tick_timer_hold))
      else $error("tick timer not reinitialised on wait entry");

   a_wd_reinit: assert property (
      (wait_entry && state_reg.wdwai) |=> (watchdog_reinit && watchdog_hold))
      else $error("watchdog not reinitialised on wait entry");

endmodule : cgsr_clock_gen
`default_nettype wire

// file: cgsr_regs.svh
// Register indexes, bit positions and reset values of the clock select and status block
`ifndef CGSR_REGS_SVH
`define CGSR_REGS_SVH

// Register indexes; byte address is four times the index
`define CGSR_IDX_PLL_POST_DIVIDER 6'h02
`define CGSR_IDX_FLAGS 6'h03
`define CGSR_IDX_IRQEN 6'h04
`define CGSR_IDX_CLOCK_SOURCE_SELECT 6'h05

// Status flag bit positions
`define CGSR_FLG_TICK 7
`define CGSR_FLG_POR 6
`define CGSR_FLG_UV 5
`define CGSR_FLG_LCHG 4
`define CGSR_FLG_LOCK 3
`define CGSR_FLG_BADA 2
`define CGSR_FLG_FCHG 1
`define CGSR_FLG_FB 0

// Clock source select bit positions
`define CGSR_SEL_PLL 7
`define CGSR_SEL_KEEP 6
`define CGSR_SEL_OSCCFG 5
`define CGSR_SEL_PLL_HALT_IN_WAIT 3
`define CGSR_SEL_TICKWAI 1
`define CGSR_SEL_WDWAI 0

// Field widths and reset values
`define CGSR_PLL_POST_DIVIDER_W 5
`define CGSR_PLL_POST_DIVIDER_RST 5'h00
`define CGSR_CNT_ONE 6'h01
`define CGSR_CNT_ZERO 6'h00
`define CGSR_BYTE_ZERO 8'h00

`endif

// file: cgsr_pkg.sv
// Types of the clock select and status block
`default_nettype none
package cgsr_pkg;

   // Sticky flags, held across system reset
   typedef struct packed {
      logic tick;
      logic por;
      logic uv;
      logic lchg;
      logic bada;
      logic fchg;
   } cgsr_flags_type;

   // Everything else, cleared by system reset except osc_en, which resets to one
   typedef struct packed {
      logic lock_s1;
      logic lock_s2;
      logic lock_d;
      logic fb_s1;
      logic fb_s2;
      logic fb_d;
      logic osc_s1;
      logic osc_s2;
      logic wait_d;
      logic stop_d;
      logic tick_en;
      logic lchg_en;
      logic fchg_en;
      logic sel_pll;
      logic keep;
      logic pll_halt_in_wait;
      logic tickwai;
      logic wdwai;
      logic wd_written;
      logic [4:0] pll_post_divider;
      logic [5:0] div_cnt;
      logic half;
      logic pll_tick;
      logic bus_tick;
      logic osc_en;
      logic pll_pd;
      logic tick_hold;
      logic tick_reinit;
      logic wd_hold;
      logic wd_reinit;
      logic irq;
      logic [31:0] prdata;
      logic pslverr;
   } cgsr_state_type;

endpackage : cgsr_pkg
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the clock select and status register block
`timescale 1ns/100ps
`default_nettype none
`include "cgsr_regs.svh"

module tb_top;
   logic pclk;
   logic presetn;
   logic poweron_rst_n;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic vco_tick;
   logic osc_tick;
   logic tick_ev;
   logic uv_ev;
   logic bada_ev;
   logic tol;
   logic fb;
   logic osc_cfg;
   logic wait_mode;
   logic stop_mode;
   logic special_mode;
   logic pll_output_tick;
   logic system_bus_tick;
   logic pll_clock_select;
   logic pll_power_down;
   logic oscillator_enable;
   logic tick_timer_hold;
   logic tick_timer_reinit;
   logic watchdog_hold;
   logic watchdog_reinit;
   logic irq_request;
   logic [31:0] rdat;
   logic rerr;
   int mismatches;
   int samples_checked;
   int np;
   int nb;
   int nr;

   cgsr_clock_gen #(.ADDR_W(8)) dut_u (.pclk(pclk), .presetn(presetn),
      .poweron_rst_n(poweron_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .vco_tick(vco_tick), .osc_tick(osc_tick),
      .periodic_tick_event(tick_ev), .undervoltage_reset_event(uv_ev),
      .bad_address_reset_event(bada_ev), .pll_tolerance_status(tol),
      .fallback_clock_active(fb), .oscillator_config_status(osc_cfg),
      .wait_mode(wait_mode), .stop_mode(stop_mode), .special_mode(special_mode),
      .pll_output_tick(pll_output_tick), .system_bus_tick(system_bus_tick),
      .pll_clock_select(pll_clock_select), .pll_power_down(pll_power_down),
      .oscillator_enable(oscillator_enable), .tick_timer_hold(tick_timer_hold),
      .tick_timer_reinit(tick_timer_reinit), .watchdog_hold(watchdog_hold),
      .watchdog_reinit(watchdog_reinit), .irq_request(irq_request));

   // 250 MHz bus clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // Verdict and end of run, shared by the main sequence and the bus timeout
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Interrupt request is registered, so look one edge after the write lands
   task automatic chk_irq(input logic exp);
      @(posedge pclk);
      check({31'h0, irq_request}, {31'h0, exp});
   endtask : chk_irq

   // Pulse counts are compared with one pulse of slack for the window phase
   task automatic near(input int got, input int exp);
      check((got >= exp - 1 && got <= exp + 1) ? 32'(exp) : 32'(got), 32'(exp));
   endtask : near

   // One APB transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         mismatches++;
         complete_run();
      end else begin
         rdat = prdata;
         rerr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      apb(1'b1, {idx, 2'b00}, d);
   endtask : wr

   task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
      apb(1'b0, {idx, 2'b00}, 8'h00);
      check(rdat, {24'h000000, exp});
   endtask : rd

   // One-cycle event pulses: {tick, undervoltage, bad address}
   task automatic ev(input logic [2:0] e);
      @(posedge pclk);
      {tick_ev, uv_ev, bada_ev} <= e;
      @(posedge pclk);
      {tick_ev, uv_ev, bada_ev} <= 3'h0;
      repeat (2) @(posedge pclk);
   endtask : ev

   // Count divider and bus pulses over a 40-cycle window
   task automatic cnt;
      np = 0;
      nb = 0;
      repeat (40) begin
         @(posedge pclk);
         np += int'(pll_output_tick === 1'b1);
         nb += int'(system_bus_tick === 1'b1);
      end
   endtask : cnt

   // Level changes on the synchronised inputs need a few edges to show
   task automatic settle;
      repeat (5) @(posedge pclk);
   endtask : settle

   task automatic enter_wait;
      nr = 0;
      @(posedge pclk);
      wait_mode <= 1'b1;
      repeat (5) begin
         @(posedge pclk);
         nr += int'(tick_timer_reinit === 1'b1) + int'(watchdog_reinit === 1'b1);
      end
   endtask : enter_wait

   initial begin
      mismatches = 0;
      samples_checked = 0;
      {presetn, poweron_rst_n, psel, penable, pwrite} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      {vco_tick, osc_tick, tick_ev, uv_ev, bada_ev, tol, fb} = 7'h00;
      {wait_mode, stop_mode, special_mode} = 3'h0;
      osc_cfg = 1'b1;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      poweron_rst_n <= 1'b1;
      settle();
      // Reset view and write-one-to-clear of the power-on flag
      rd(`CGSR_IDX_FLAGS, 8'h40);
      rd(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'h20);
      wr(`CGSR_IDX_FLAGS, 8'h00);
      rd(`CGSR_IDX_FLAGS, 8'h40);
      wr(`CGSR_IDX_FLAGS, 8'h40);
      rd(`CGSR_IDX_FLAGS, 8'h00);
      // Tick flag and its interrupt enable
      ev(3'h4);
      rd(`CGSR_IDX_FLAGS, 8'h80);
      wr(`CGSR_IDX_IRQEN, 8'h80);
      chk_irq(1'b1);
      wr(`CGSR_IDX_FLAGS, 8'h00);
      rd(`CGSR_IDX_FLAGS, 8'h80);
      wr(`CGSR_IDX_FLAGS, 8'h80);
      rd(`CGSR_IDX_FLAGS, 8'h00);
      chk_irq(1'b0);
      // Reset flags survive a system reset; undervoltage clears bad address
      ev(3'h2);
      ev(3'h1);
      rd(`CGSR_IDX_FLAGS, 8'h24);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      rd(`CGSR_IDX_FLAGS, 8'h24);
      rd(`CGSR_IDX_IRQEN, 8'h00);
      ev(3'h2);
      rd(`CGSR_IDX_FLAGS, 8'h20);
      wr(`CGSR_IDX_FLAGS, 8'h20);
      rd(`CGSR_IDX_FLAGS, 8'h00);
      // PLL select refused while unlocked; watchdog halt bit write-once
      wr(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'h81);
      rd(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'h21);
      wr(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'h00);
      rd(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'h21);
      special_mode <= 1'b1;
      wr(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'h00);
      rd(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'h20);
      special_mode <= 1'b0;
      // Lock gained: status and change flag, interrupt
      tol <= 1'b1;
      settle();
      rd(`CGSR_IDX_FLAGS, 8'h18);
      wr(`CGSR_IDX_FLAGS, 8'h08);
      rd(`CGSR_IDX_FLAGS, 8'h18);
      wr(`CGSR_IDX_IRQEN, 8'h10);
      chk_irq(1'b1);
      wr(`CGSR_IDX_FLAGS, 8'h10);
      rd(`CGSR_IDX_FLAGS, 8'h08);
      // Post divider and bus rate from oscillator
      wr(`CGSR_IDX_PLL_POST_DIVIDER, 8'h02);
      rd(`CGSR_IDX_PLL_POST_DIVIDER, 8'h02);
      vco_tick <= 1'b1;
      osc_tick <= 1'b1;
      cnt();
      near(np, 10);
      near(nb, 20);
      wr(`CGSR_IDX_PLL_POST_DIVIDER, 8'h00);
      cnt();
      near(np, 40);
      wr(`CGSR_IDX_PLL_POST_DIVIDER, 8'h02);
      // PLL selected: read back, divider locked, bus from PLL output
      wr(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'h80);
      rd(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'ha0);
      wr(`CGSR_IDX_PLL_POST_DIVIDER, 8'h05);
      rd(`CGSR_IDX_PLL_POST_DIVIDER, 8'h02);
      cnt();
      near(nb, 5);
      // Fallback mode entry and exit
      fb <= 1'b1;
      settle();
      rd(`CGSR_IDX_FLAGS, 8'h13);
      rd(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'h20);
      wr(`CGSR_IDX_IRQEN, 8'h02);
      wr(`CGSR_IDX_FLAGS, 8'h10);
      chk_irq(1'b1);
      wr(`CGSR_IDX_FLAGS, 8'h02);
      chk_irq(1'b0);
      fb <= 1'b0;
      settle();
      rd(`CGSR_IDX_FLAGS, 8'h1a);
      wr(`CGSR_IDX_FLAGS, 8'h12);
      // Stop mode with and without the oscillator kept running
      wr(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'h8a);
      rd(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'haa);
      stop_mode <= 1'b1;
      settle();
      check({30'h0, oscillator_enable, pll_clock_select}, 32'h0);
      stop_mode <= 1'b0;
      wr(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'hc8);
      stop_mode <= 1'b1;
      settle();
      check({30'h0, oscillator_enable, pll_clock_select}, 32'h2);
      stop_mode <= 1'b0;
      // Wait mode with all halt bits set, then with none
      special_mode <= 1'b1;
      wr(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'h8b);
      rd(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'hab);
      enter_wait();
      check(32'(nr), 32'h2);
      check({28'h0, pll_clock_select, pll_power_down, tick_timer_hold, watchdog_hold},
         32'h7);
      rd(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'h2b);
      wait_mode <= 1'b0;
      wr(`CGSR_IDX_CLOCK_SOURCE_SELECT, 8'h80);
      enter_wait();
      check(32'(nr), 32'h0);
      check({28'h0, pll_clock_select, pll_power_down, tick_timer_hold, watchdog_hold},
         32'h8);
      wait_mode <= 1'b0;
      special_mode <= 1'b0;
      // Unmapped address answers with an error
      apb(1'b0, 8'h40, 8'h00);
      check({31'h0, rerr}, 32'h1);
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
